// ---- core/iop_pkg.sv ----
// Package for the I/O ring port performance event selector.
package iop_pkg;

    // ********************************************************************
    // Event codes
    // ********************************************************************
    localparam logic [7:0] EV_UNIT_CLOCK      = 8'h00;
    localparam logic [7:0] EV_DRS_INSERTS     = 8'h01;
    localparam logic [7:0] EV_NCB_INSERTS     = 8'h02;
    localparam logic [7:0] EV_NCS_INSERTS     = 8'h03;
    localparam logic [7:0] EV_DRS_FULL        = 8'h04;
    localparam logic [7:0] EV_NCB_FULL        = 8'h05;
    localparam logic [7:0] EV_NCS_FULL        = 8'h06;
    localparam logic [7:0] EV_DRS_OCCUPANCY   = 8'h07;
    localparam logic [7:0] EV_NCB_OCCUPANCY   = 8'h08;
    localparam logic [7:0] EV_NCS_OCCUPANCY   = 8'h09;
    localparam logic [7:0] EV_RSP_INSERTS     = 8'h0a;
    localparam logic [7:0] EV_RSP_FULL        = 8'h0b;
    localparam logic [7:0] EV_RSP_OCCUPANCY   = 8'h0c;
    localparam logic [7:0] EV_OUT_OCCUPANCY   = 8'h0d;
    localparam logic [7:0] EV_OUT_NCB_ISSUE   = 8'h0e;
    localparam logic [7:0] EV_OUT_NCS_ISSUE   = 8'h0f;
    localparam logic [7:0] EV_TRANSACTIONS    = 8'h15;
    localparam logic [7:0] EV_TICKLES         = 8'h16;
    localparam logic [7:0] EV_ADDR_STALL      = 8'h18;
    localparam logic [7:0] EV_DATA_STALL      = 8'h19;
    localparam logic [7:0] EV_WR_ORDER_STALL  = 8'h1a;

    // ********************************************************************
    // Control word layout and unit-mask bits
    // ********************************************************************
    localparam int CTL_EVENT_LSB   = 0;
    localparam int CTL_UMASK_LSB   = 8;
    localparam int CTL_UMASK_MSB   = 15;
    localparam int TK_LOST_BIT     = 0;
    localparam int TK_HEAD_BIT     = 1;
    localparam int TR_READ_BIT     = 0;
    localparam int TR_WRITE_BIT    = 1;
    localparam int TR_PREFETCH_BIT = 2;
    localparam int TR_SOURCE_BIT   = 3;

    // ********************************************************************
    // Sizes and reset values
    // ********************************************************************
    localparam int NUM_COUNTERS    = 2;
    localparam int QUEUE_MAX       = 24;
    localparam int OCC_W           = 5;
    localparam int SRC_W           = 5;
    localparam int NUM_CLASSES     = 3;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [NUM_CLASSES-1:0] alloc;
        logic [NUM_CLASSES-1:0] full;
        logic [NUM_CLASSES*OCC_W-1:0] occ;
    } iop_data_ingress_t;

    typedef struct packed {
        logic             alloc;
        logic             full;
        logic [OCC_W-1:0] occ;
    } iop_rsp_ingress_t;

    typedef struct packed {
        logic             valid;
        logic             is_read;
        logic             is_write;
        logic             is_prefetch;
        logic [SRC_W-1:0] source;
    } iop_txn_t;

endpackage : iop_pkg

// ---- core/iop_event_select.sv ----
// Event selection and per-counter increments for the I/O ring port unit.
//
// Implementation choices: the placing of the registers and the two direct control-word ports.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (RULE1) Code 0x00 adds one every unit clock cycle.
// (RULE2) Code 0x0b adds one while the response ingress queue is full.
// (RULE3) Code 0x0a adds one per allocation into the response ingress queue.
// (RULE4) Code 0x0c adds the response ingress occupancy, at most 24, each cycle.
// (RULE5) Codes 0x04-0x06 count full cycles of each data ingress class queue.
// (RULE6) Codes 0x01-0x03 count allocations into each data ingress class queue.
// (RULE7) Codes 0x07-0x09 add each data ingress class occupancy, at most 24.
// (RULE8) Code 0x16 counts explicit and implicit tickles received.
// (RULE9) Tickle mask bit 0 counts each request losing ownership on a tickle.
// (RULE10) Tickle mask bit 1 counts tickles hitting the head of queue.
// (RULE11) Code 0x15 ORs type mask bits, then ANDs source match if selected.
// (RULE12) Transaction mask bit 0 counts reads but not read prefetches.
// (RULE13) Transaction mask bit 1 counts writes, each retry counted again.
// (RULE14) Transaction mask bit 2 counts read prefetches.
// (RULE15) Transaction mask bit 3 restricts counting to the filtered source queue.
// (RULE16) Code 0x18 counts request stalls for lack of address-channel credit.
// (RULE17) Code 0x19 counts data stalls for lack of data-channel credit.
// (RULE18) Codes 0x0e and 0x0f count bypass and standard requests to the switch.
// (RULE19) Code 0x0d adds the outstanding outbound request count each cycle.
// (RULE20) Code 0x1a counts ack-pending cycles with an idle switch pipeline.
// (RULE21) Only counters 0 and 1 exist; non-occupancy events add at most one. Code 0x16 with mask bit 0 adds tickle_lost_cnt instead.
// (RULE22) Unit mask sits in control bits 15:8 beside the event code.
// (RULE23) Increment chosen from code and mask; unknown codes add zero.
module iop_event_select #(
    parameter int OUT_W = 8                     // Width of the outstanding request count.
) (
    input  wire logic                          clk,            // Unit clock, 20 MHz.
    input  wire logic                          rst,            // Synchronous reset, active high.
    input  wire logic                          ce,             // Clock enable; low freezes state.
    input  wire logic [31:0]                   ctl0,           // Control word of counter 0.
    input  wire logic [31:0]                   ctl1,           // Control word of counter 1.
    input  wire logic [iop_pkg::SRC_W-1:0]     source_queue_filter, // Selected source queue.
    input  wire iop_pkg::iop_rsp_ingress_t     rsp_ingress,    // Response ingress status.
    input  wire iop_pkg::iop_data_ingress_t    data_ingress,   // Data ingress status per class.
    input  wire logic                          tickle_in,      // Tickle received this cycle.
    input  wire logic                          tickle_at_head, // Tickled request is at head.
    input  wire logic [iop_pkg::OCC_W-1:0]     tickle_lost_cnt, // Requests losing ownership.
    input  wire iop_pkg::iop_txn_t             txn,            // Inbound transaction issued.
    input  wire logic                          addr_credit_stall, // No address egress credit.
    input  wire logic                          data_credit_stall, // No data egress credit.
    input  wire logic                          issue_ncb,      // Bypass request to switch.
    input  wire logic                          issue_ncs,      // Standard request to switch.
    input  wire logic [OUT_W-1:0]              out_outstanding, // Outbound requests pending.
    input  wire logic                          ack_pending,    // Write acks pending in switch.
    input  wire logic                          switch_pipe_busy, // Switch to port pipe in use.
    output logic [OUT_W-1:0]                   inc0,           // Increment for counter 0.
    output logic [OUT_W-1:0]                   inc1            // Increment for counter 1.
);

    // ********************************************************************
    // Parameter check
    // ********************************************************************
    if (OUT_W < iop_pkg::OCC_W)
    begin : g_bad_width
        $error("OUT_W must hold a queue occupancy of 24");
    end

    // ********************************************************************
    // Registered control words
    // ********************************************************************
    // Control words are registered so a reprogramming takes two clean cycles to
    // reach the adders; counters never see a half-written selection.
    logic [31:0] ctl_q [iop_pkg::NUM_COUNTERS];
    logic [OUT_W-1:0] next_inc [iop_pkg::NUM_COUNTERS];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctl_q[0] <= iop_pkg::CTL_RESET;
            ctl_q[1] <= iop_pkg::CTL_RESET;
        end
        else if (ce)
        begin
            ctl_q[0] <= ctl0;
            ctl_q[1] <= ctl1;
        end
    end

    // ********************************************************************
    // Shared event terms
    // ********************************************************************
    logic src_hit;
    logic [iop_pkg::OCC_W-1:0] occ_cls [iop_pkg::NUM_CLASSES];

    assign src_hit = (txn.source == source_queue_filter);

    genvar gc;
    generate
        for (gc = 0; gc < iop_pkg::NUM_CLASSES; gc++)
        begin : g_cls
            assign occ_cls[gc] = data_ingress.occ[gc*iop_pkg::OCC_W +: iop_pkg::OCC_W];
        end
    endgenerate

    // ********************************************************************
    // Per-counter selection
    // ********************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < iop_pkg::NUM_COUNTERS; gi++) // RULE21
        begin : g_ctr
            logic [7:0] code;
            logic [7:0] umask;
            logic       type_hit;
            logic       txn_hit;

            assign code  = ctl_q[gi][iop_pkg::CTL_EVENT_LSB +: 8];
            assign umask = ctl_q[gi][iop_pkg::CTL_UMASK_MSB:iop_pkg::CTL_UMASK_LSB]; // RULE22

            assign type_hit = (umask[iop_pkg::TR_READ_BIT] & txn.is_read
                                   & ~txn.is_prefetch)                 // RULE12
                            | (umask[iop_pkg::TR_WRITE_BIT] & txn.is_write) // RULE13
                            | (umask[iop_pkg::TR_PREFETCH_BIT] & txn.is_read
                                   & txn.is_prefetch);                 // RULE14
            assign txn_hit = txn.valid & type_hit
                           & (~umask[iop_pkg::TR_SOURCE_BIT] | src_hit); // RULE11 RULE15

            always_comb
            begin
                next_inc[gi] = '0;
                case (code) // RULE23
                    iop_pkg::EV_UNIT_CLOCK:     next_inc[gi] = OUT_W'(1); // RULE1
                    iop_pkg::EV_RSP_FULL:       next_inc[gi] = OUT_W'(rsp_ingress.full); // RULE2
                    iop_pkg::EV_RSP_INSERTS:    next_inc[gi] = OUT_W'(rsp_ingress.alloc); // RULE3
                    iop_pkg::EV_RSP_OCCUPANCY:  next_inc[gi] = OUT_W'(rsp_ingress.occ); // RULE4
                    iop_pkg::EV_DRS_FULL:       next_inc[gi] = OUT_W'(data_ingress.full[0]); // RULE5
                    iop_pkg::EV_NCB_FULL:       next_inc[gi] = OUT_W'(data_ingress.full[1]);
                    iop_pkg::EV_NCS_FULL:       next_inc[gi] = OUT_W'(data_ingress.full[2]);
                    iop_pkg::EV_DRS_INSERTS:    next_inc[gi] = OUT_W'(data_ingress.alloc[0]); // RULE6
                    iop_pkg::EV_NCB_INSERTS:    next_inc[gi] = OUT_W'(data_ingress.alloc[1]);
                    iop_pkg::EV_NCS_INSERTS:    next_inc[gi] = OUT_W'(data_ingress.alloc[2]);
                    iop_pkg::EV_DRS_OCCUPANCY:  next_inc[gi] = OUT_W'(occ_cls[0]); // RULE7
                    iop_pkg::EV_NCB_OCCUPANCY:  next_inc[gi] = OUT_W'(occ_cls[1]);
                    iop_pkg::EV_NCS_OCCUPANCY:  next_inc[gi] = OUT_W'(occ_cls[2]);
                    iop_pkg::EV_TICKLES:
                    begin
                        // With no mask bit set every tickle counts once.
                        if (umask[1:0] == 2'h0)
                        begin
                            next_inc[gi] = OUT_W'(tickle_in); // RULE8
                        end
                        else
                        begin
                            if (umask[iop_pkg::TK_LOST_BIT] && tickle_in && !tickle_at_head)
                            begin
                                next_inc[gi] = OUT_W'(tickle_lost_cnt); // RULE9
                            end
                            if (umask[iop_pkg::TK_HEAD_BIT] && tickle_in && tickle_at_head)
                            begin
                                next_inc[gi] = OUT_W'(1); // RULE10
                            end
                        end
                    end
                    iop_pkg::EV_TRANSACTIONS:   next_inc[gi] = OUT_W'(txn_hit); // RULE11
                    iop_pkg::EV_ADDR_STALL:     next_inc[gi] = OUT_W'(addr_credit_stall); // RULE16
                    iop_pkg::EV_DATA_STALL:     next_inc[gi] = OUT_W'(data_credit_stall); // RULE17
                    iop_pkg::EV_OUT_NCB_ISSUE:  next_inc[gi] = OUT_W'(issue_ncb); // RULE18
                    iop_pkg::EV_OUT_NCS_ISSUE:  next_inc[gi] = OUT_W'(issue_ncs);
                    iop_pkg::EV_OUT_OCCUPANCY:  next_inc[gi] = out_outstanding; // RULE19
                    iop_pkg::EV_WR_ORDER_STALL:
                        next_inc[gi] = OUT_W'(ack_pending & ~switch_pipe_busy); // RULE20
                    default:                    next_inc[gi] = '0; // RULE23
                endcase
            end
        end
    endgenerate

    // ********************************************************************
    // Registered increments
    // ********************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            inc0 <= '0;
            inc1 <= '0;
        end
        else if (ce)
        begin
            inc0 <= next_inc[0];
            inc1 <= next_inc[1];
        end
    end

endmodule : iop_event_select

`default_nettype wire

// ---- verif/iop_event_select_assertions.sv ----
// Port-level checks of the I/O ring port event selector.
`timescale 1ns/1ps
`default_nettype none
module iop_event_select_assertions #(
    parameter int OUT_W = 8                        // Increment width.
) (
    input wire logic                       clk,              // Unit clock.
    input wire logic                       rst,              // Reset.
    input wire logic                       ce,               // Clock enable.
    input wire logic [31:0]                ctl0,             // Control 0.
    input wire logic [31:0]                ctl1,             // Control 1.
    input wire iop_pkg::iop_rsp_ingress_t  rsp_ingress,      // Response ingress.
    input wire iop_pkg::iop_data_ingress_t data_ingress,     // Data ingress.
    input wire iop_pkg::iop_txn_t          txn,              // Transaction.
    input wire logic                       ack_pending,      // Acks pending.
    input wire logic                       switch_pipe_busy, // Pipe busy.
    input wire logic [OUT_W-1:0]           inc0,             // Increment 0.
    input wire logic [OUT_W-1:0]           inc1              // Increment 1.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Two clean enabled edges are needed before ctl and events fully explain inc.
    logic [1:0] run_q;
    always_ff @(posedge clk) run_q <= {run_q[0], ce & ~rst};

    clock_tick_a: assert property (
        &run_q && $past(ctl0[7:0], 2) == 8'h00 |-> inc0 == 8'h01) else $error("tick lost");
    rsp_full_a: assert property (
        &run_q && $past(ctl0[7:0], 2) == 8'h0b |-> inc0 == $past(rsp_ingress.full))
        else $error("full count wrong");
    rsp_occ_a: assert property (
        &run_q && $past(ctl0[7:0], 2) == 8'h0c |-> inc0 == $past(rsp_ingress.occ))
        else $error("occupancy wrong");
    ncb_full_a: assert property (
        &run_q && $past(ctl1[7:0], 2) == 8'h05 |-> inc1 == $past(data_ingress.full[1]))
        else $error("class full wrong");
    ncs_occ_a: assert property (
        &run_q && $past(ctl1[7:0], 2) == 8'h09 |-> inc1 == $past(data_ingress.occ[14:10]))
        else $error("class occupancy wrong");
    read_only_a: assert property (
        &run_q && $past(ctl0[15:0], 2) == 16'h0115
        |-> inc0 == $past(txn.valid & txn.is_read & ~txn.is_prefetch)) else $error("reads wrong");
    wr_order_a: assert property (
        &run_q && $past(ctl0[7:0], 2) == 8'h1a
        |-> inc0 == $past(ack_pending & ~switch_pipe_busy)) else $error("ordering stall wrong");
    unknown_code_a: assert property (
        &run_q && $past(ctl1[7:0], 2) == 8'h1f |-> inc1 == 0) else $error("unknown code counted");
endmodule : iop_event_select_assertions

bind iop_event_select iop_event_select_assertions #(.OUT_W(OUT_W)) iop_event_select_assertions_i (
    .clk, .rst, .ce, .ctl0, .ctl1, .rsp_ingress, .data_ingress, .txn, .ack_pending,
    .switch_pipe_busy, .inc0, .inc1);
`default_nettype wire

// ---- verif/iop_ring_agent_model.sv ----
// Behavioural ring agent filling the response ingress queue.
`timescale 1ns/1ps
`default_nettype none
module iop_ring_agent_model (
    input  wire logic                      clk,         // Unit clock.
    input  wire logic                      rst,         // Reset.
    input  wire logic                      push,        // Offer a response.
    input  wire logic                      pop,         // Retire a response.
    output var  iop_pkg::iop_rsp_ingress_t rsp_ingress  // Queue status.
);
    logic [4:0] occ;
    // A response offered to a full queue is refused, so the fill never passes 24.
    always_comb rsp_ingress = '{alloc: push && occ != 5'h18, full: occ == 5'h18, occ: occ};
    always_ff @(posedge clk)
        if (rst)
            occ <= 5'h00;
        else
            occ <= occ + 5'(rsp_ingress.alloc) - 5'(pop && occ != 5'h00);
endmodule : iop_ring_agent_model
`default_nettype wire

// ---- verif/iop_event_select_tb.sv ----
// Testbench of the I/O ring port event selector.
`timescale 1ns/1ps
`default_nettype none
module iop_event_select_tb;
    logic clk, rst, ce, push, pop, chk_on, tickle_in, tickle_at_head;
    logic addr_credit_stall, data_credit_stall, issue_ncb, issue_ncs, ack_pending;
    logic switch_pipe_busy;
    logic [31:0]               ctl0, ctl1;
    logic [4:0]                source_queue_filter, tickle_lost_cnt;
    logic [7:0]                out_outstanding, inc0, inc1, e0, e1;
    logic [15:0]               c0, c1;
    iop_pkg::iop_rsp_ingress_t  rsp_ingress;
    iop_pkg::iop_data_ingress_t data_ingress;
    iop_pkg::iop_txn_t          txn;
    int                        fails, total_checks;
    logic [15:0] cw [32] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
        16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000c, 16'h000d,
        16'h000e, 16'h000f, 16'h0016, 16'h0116, 16'h0216, 16'h0316, 16'h0115, 16'h0215,
        16'h0415, 16'h0815, 16'h0915, 16'h0715, 16'h0f15, 16'h0018, 16'h0019, 16'h001a,
        16'h001f, 16'hff14};

    iop_event_select iop_event_select_i (.clk, .rst, .ce, .ctl0, .ctl1, .source_queue_filter,
        .rsp_ingress, .data_ingress, .tickle_in, .tickle_at_head, .tickle_lost_cnt, .txn,
        .addr_credit_stall, .data_credit_stall, .issue_ncb, .issue_ncs, .out_outstanding,
        .ack_pending, .switch_pipe_busy, .inc0, .inc1);
    iop_ring_agent_model iop_ring_agent_model_i (.clk, .rst, .push, .pop, .rsp_ingress);

    function automatic logic [7:0] exp_inc(input logic [15:0] c);
        logic [7:0] m;
        logic       t;
        m = c[15:8];
        t = (m[0] & txn.is_read & ~txn.is_prefetch) | (m[1] & txn.is_write)
            | (m[2] & txn.is_read & txn.is_prefetch);
        case (c[7:0])
            8'h00: return 8'h01;
            8'h01, 8'h02, 8'h03: return 8'(data_ingress.alloc[c[1:0] - 2'd1]);
            8'h04, 8'h05, 8'h06: return 8'(data_ingress.full[c[1:0]]);
            8'h07, 8'h08, 8'h09: return 8'(data_ingress.occ[5 * (c[3:0] - 4'd7) +: 5]);
            8'h0a: return 8'(rsp_ingress.alloc);
            8'h0b: return 8'(rsp_ingress.full);
            8'h0c: return 8'(rsp_ingress.occ);
            8'h0d: return out_outstanding;
            8'h0e: return 8'(issue_ncb);
            8'h0f: return 8'(issue_ncs);
            8'h15: return 8'(txn.valid & t & (~m[3] | txn.source == source_queue_filter));
            8'h16: return !tickle_in ? 8'h00 : m[1:0] == 2'b00 ? 8'h01 :
                8'(m[0] & ~tickle_at_head ? tickle_lost_cnt : 5'h00) + 8'(m[1] & tickle_at_head);
            8'h18: return 8'(addr_credit_stall);
            8'h19: return 8'(data_credit_stall);
            8'h1a: return 8'(ack_pending & ~switch_pipe_busy);
            default: return 8'h00;
        endcase
    endfunction : exp_inc

    task automatic set_ev(input int k);
        data_ingress <= (k == 0) ? {3'b101, 3'b010, 5'd24, 5'd3, 5'd17}
                                 : {3'b010, 3'b101, 5'd9, 5'd24, 5'd0};
        txn <= (k == 0) ? {4'b1100, 5'd7} : (k == 1) ? {4'b1101, 5'd3} : {4'b1010, 5'd7};
        source_queue_filter <= 5'(k == 0 ? 7 : k == 1 ? 3 : 9);
        tickle_in <= k != 2;
        tickle_at_head <= k == 1;
        tickle_lost_cnt <= 5'(k + 4);
        addr_credit_stall <= k == 0;
        data_credit_stall <= k == 1;
        issue_ncb <= k != 1;
        issue_ncs <= k == 1;
        out_outstanding <= (k == 0) ? 8'd200 : 8'(k * 31);
        ack_pending <= k != 2;
        switch_pipe_busy <= k == 1;
    endtask : set_ev

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: increment %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Reference pipeline: control word taken one edge, events the next.
    // The model reads its inputs before the edge's updates land, as the design does,
    // and compares only once the registered increments have settled.
    always @(posedge clk)
    begin
        if (rst)
        begin
            {e0, e1, c0, c1} = '0;
        end
        else if (ce)
        begin
            e0 = exp_inc(c0);
            e1 = exp_inc(c1);
            c0 = ctl0[15:0];
            c1 = ctl1[15:0];
        end
        #1;
        if (chk_on)
        begin
            chk(inc0, e0);
            chk(inc1, e1);
        end
    end

    initial
    begin
        {rst, ce, push, pop, chk_on, ctl0, ctl1, fails, total_checks} = {2'b11, 3'b000, 64'h0, 64'h0};
        set_ev(2);
        repeat (3) @(posedge clk);
        chk_on = 1'b1;
        repeat (13) @(posedge clk);
        rst <= 1'b0;
        ce <= 1'b1;
        ctl0 <= 32'h0000_000a;
        ctl1 <= 32'h0000_000c;
        push <= 1'b1;
        repeat (26) @(posedge clk);
        push <= 1'b0;
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < 32; i++)
            begin
                @(posedge clk);
                ctl0 <= {16'h0000, cw[i]};
                ctl1 <= {16'h0000, cw[(i + 7) % 32]};
                set_ev(k);
                ce <= !(k == 1 && i == 5);
                @(posedge clk);
            end
        ctl0 <= 32'h0000_000b;
        ctl1 <= 32'h0000_000c;
        pop <= 1'b1;
        repeat (26) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule : iop_event_select_tb
`default_nettype wire
